// ### core/tpw_timer.sv
// 8-bit timer with fast and phase correct PWM on one compare output.
// Assumes configuration ports come from logic on i_clk_sys and the
// timer oscillator arrives unsynchronised on a pin.
`timescale 1ns/1ns
module tpw_timer
	import tpw_pkg::*;
(
	// Clock, reset, freeze
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	// Configuration
	input wire tpw_cfg_type i_cfg,
	// Compare value write port
	input wire logic i_compare_wr,
	input wire logic [CNT_W-1:0] i_compare_value,
	// Flag clears
	input wire logic i_overflow_clr,
	input wire logic i_match_clr,
	// Timer oscillator pin
	input wire logic i_osc_clk,
	// General port function of the pin
	input wire logic i_port_out,
	input wire logic i_dir_out,
	// Status
	output logic [CNT_W-1:0] o_count_value,
	output logic [CNT_W-1:0] o_compare_active,
	output logic o_compare_output,
	output logic o_overflow_flag,
	output logic o_match_flag,
	// Pin drive
	output tpw_pin_type o_waveform_pin
);

	// Oscillator synchroniser and edge history
	logic osc_meta;
	logic osc_sync;
	logic osc_prev;
	logic next_osc_meta;
	logic next_osc_sync;
	logic next_osc_prev;
	// Prescaler count
	logic [PRE_W-1:0] pre_cnt;
	logic [PRE_W-1:0] next_pre_cnt;
	logic [PRE_W-1:0] pre_mask;
	// Source and timer ticks
	logic src_tick;
	logic timer_tick;

	// Counter group state
	logic [CNT_W-1:0] count_value;
	logic [CNT_W-1:0] next_count_value;
	tpw_dir_type dir;
	tpw_dir_type next_dir;
	logic [CNT_W-1:0] compare_buf;
	logic [CNT_W-1:0] next_compare_buf;
	logic [CNT_W-1:0] compare_act;
	logic [CNT_W-1:0] next_compare_act;
	logic compare_output;
	logic next_compare_output;
	logic overflow_flag;
	logic next_overflow_flag;
	logic match_flag;
	logic next_match_flag;
	// Decoded helpers
	logic is_pwm;
	logic match;
	logic up_lvl;
	logic down_lvl;
	// Tick taken outside reset; the checks qualify on it so a release edge is not mistaken for a step
	logic run_tick;

	// Output for an action at a match: toggle, force a level, or hold
	function automatic logic act_out(input logic [1:0] act, input logic cur, input logic lvl);
		logic res;
		res = cur;
		case (act)
			ACT_TOGGLE: res = ~cur;
			ACT_NONINV: res = lvl;
			ACT_INV: res = lvl;
			default: res = cur;
		endcase
		return res;
	endfunction : act_out

	// Prescaler mask; the stop code gates the tick instead
	always_comb begin
		case (i_cfg.prescale)
			PRE_DIV1: pre_mask = MASK_DIV1;
			PRE_DIV8: pre_mask = MASK_DIV8;
			PRE_DIV32: pre_mask = MASK_DIV32;
			PRE_DIV64: pre_mask = MASK_DIV64;
			PRE_DIV128: pre_mask = MASK_DIV128;
			PRE_DIV256: pre_mask = MASK_DIV256;
			default: pre_mask = MASK_DIV1024;
		endcase
	end

	// Tick source: every cycle, or a synchronised oscillator rising edge
	always_comb begin
		next_osc_meta = i_osc_clk;
		next_osc_sync = osc_meta;
		next_osc_prev = osc_sync;
		// Edge read from the second stage only, never the first
		src_tick = i_cfg.async_sel ? (osc_sync & ~osc_prev) : 1'b1;
		next_pre_cnt = src_tick ? pre_cnt + 10'h001 : pre_cnt;
		// Free-running prescaler; a select change may shorten one period
		timer_tick = src_tick && (i_cfg.prescale != PRE_STOP) && ((pre_cnt & pre_mask) == pre_mask);
	end

	// Synchroniser and prescaler registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
			pre_cnt <= '0;
		end else if (i_clk_en) begin
			osc_meta <= next_osc_meta;
			osc_sync <= next_osc_sync;
			osc_prev <= next_osc_prev;
			pre_cnt <= next_pre_cnt;
		end
	end

	// Level decode of the action selector
	always_comb begin
		// Up-count match level; the down level is its inverse
		up_lvl = (i_cfg.action == ACT_INV);
		down_lvl = ~up_lvl;
		is_pwm = (i_cfg.mode == MODE_FAST) || (i_cfg.mode == MODE_PHASE);
		match = (count_value == compare_act);
		// Reset wins over the tick in the release edge, so the checks must see reset too
		run_tick = i_nrst && i_clk_en && timer_tick;
	end

	// Counter, compare and output next-state
	always_comb begin
		next_count_value = count_value;
		next_dir = dir;
		next_compare_buf = compare_buf;
		next_compare_act = compare_act;
		next_compare_output = compare_output;
		next_overflow_flag = overflow_flag;
		next_match_flag = match_flag;
		// Software writes land in the buffer, and in PWM modes only there
		if (i_compare_wr) begin
			next_compare_buf = i_compare_value;
		end
		// Outside PWM the buffer is transparent
		if (!is_pwm) begin
			next_compare_act = next_compare_buf;
		end
		// Clears first, so a set in the same cycle wins
		if (i_overflow_clr) begin
			next_overflow_flag = 1'b0;
		end
		if (i_match_clr) begin
			next_match_flag = 1'b0;
		end
		if (timer_tick) begin
			// Flag shows after the tick that saw equality
			if (match) begin
				next_match_flag = 1'b1;
			end
			case (i_cfg.mode)
				MODE_FAST: begin
					if (match) begin
						next_compare_output = act_out(i_cfg.action, compare_output, up_lvl);
					end
					if (count_value == CNT_MAX) begin
						next_count_value = CNT_BOTTOM;
						next_compare_act = next_compare_buf;
						// Bottom action overrides a match at max: steady level
						if (i_cfg.action[1]) begin
							next_compare_output = down_lvl;
						end
					end else begin
						next_count_value = count_value + CNT_ONE;
					end
					if (count_value == CNT_MAX - CNT_ONE) begin
						next_overflow_flag = 1'b1;
					end
				end
				MODE_PHASE: begin
					case (dir)
						DIR_UP: begin
							if (match) begin
								next_compare_output = act_out(i_cfg.action, compare_output, up_lvl);
							end
							if (count_value == CNT_MAX) begin
								// One tick at max, then fall
								next_dir = DIR_DOWN;
								next_count_value = CNT_MAX - CNT_ONE;
								next_compare_act = next_compare_buf;
								// Level at max: steady if still max, else the up-match level
								if (i_cfg.action[1]) begin
									next_compare_output = (next_compare_buf == CNT_MAX) ? down_lvl : up_lvl;
								end
							end else begin
								next_count_value = count_value + CNT_ONE;
							end
						end
						DIR_DOWN: begin
							if (count_value == CNT_BOTTOM) begin
								// Bottom match counts as up-going: output takes the up-match level, steady low only for non-inverting
								if (match) begin
									next_compare_output = act_out(i_cfg.action, compare_output, up_lvl);
								end
								next_dir = DIR_UP;
								next_count_value = CNT_ONE;
							end else begin
								if (match) begin
									next_compare_output = act_out(i_cfg.action, compare_output, down_lvl);
								end
								next_count_value = count_value - CNT_ONE;
								if (count_value == CNT_ONE) begin
									next_overflow_flag = 1'b1;
								end
							end
						end
						default: begin
							next_dir = DIR_UP;
						end
					endcase
				end
				default: begin
					// Non-PWM modes: plain up count, no output action
					next_count_value = count_value + CNT_ONE;
					next_dir = DIR_UP;
					if (count_value == CNT_MAX) begin
						next_overflow_flag = 1'b1;
					end
				end
			endcase
		end
	end

	// Counter group registers; low clock enable freezes everything
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			count_value <= CNT_BOTTOM;
			dir <= DIR_UP;
			compare_buf <= CNT_BOTTOM;
			compare_act <= CNT_BOTTOM;
			compare_output <= 1'b0;
			overflow_flag <= 1'b0;
			match_flag <= 1'b0;
		end else if (i_clk_en) begin
			count_value <= next_count_value;
			dir <= next_dir;
			compare_buf <= next_compare_buf;
			compare_act <= next_compare_act;
			compare_output <= next_compare_output;
			overflow_flag <= next_overflow_flag;
			match_flag <= next_match_flag;
		end
	end

	// Status outputs straight from flip-flops
	assign o_count_value = count_value;
	assign o_compare_active = compare_act;
	assign o_compare_output = compare_output;
	assign o_overflow_flag = overflow_flag;
	assign o_match_flag = match_flag;
	// Pin mux; direction alone decides whether the pin is driven
	assign o_waveform_pin.out = (i_cfg.action != ACT_NONE) ? compare_output : i_port_out;
	assign o_waveform_pin.oe = i_dir_out;

	// Checks on the counter, flags and output
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	fast_step_a: assert property (run_tick && i_cfg.mode == MODE_FAST && count_value != CNT_MAX
		|=> count_value == $past(count_value) + CNT_ONE) else $error("fast count did not step");
	fast_wrap_a: assert property (run_tick && i_cfg.mode == MODE_FAST && count_value == CNT_MAX
		|=> count_value == CNT_BOTTOM) else $error("fast count did not wrap");
	fast_ovf_a: assert property (run_tick && i_cfg.mode == MODE_FAST
		&& count_value == CNT_MAX - CNT_ONE |=> overflow_flag) else $error("fast overflow missed");
	fast_noninv_a: assert property (run_tick && i_cfg.mode == MODE_FAST && count_value == CNT_MAX
		&& i_cfg.action == ACT_NONINV |=> compare_output) else $error("bottom set missed");
	fast_inv_a: assert property (run_tick && i_cfg.mode == MODE_FAST && count_value == CNT_MAX
		&& i_cfg.action == ACT_INV |=> !compare_output) else $error("bottom clear missed");
	phase_turn_a: assert property (run_tick && i_cfg.mode == MODE_PHASE && dir == DIR_UP
		&& count_value == CNT_MAX |=> dir == DIR_DOWN && count_value == CNT_MAX - CNT_ONE)
		else $error("phase turn at max wrong");
	phase_ovf_a: assert property (run_tick && i_cfg.mode == MODE_PHASE && dir == DIR_DOWN
		&& count_value == CNT_ONE |=> overflow_flag && count_value == CNT_BOTTOM)
		else $error("phase overflow missed");
	match_flag_a: assert property (run_tick && match |=> match_flag)
		else $error("match flag missed");
	buffer_hold_a: assert property (i_nrst && i_clk_en && i_cfg.mode == MODE_FAST
		&& !(timer_tick && count_value == CNT_MAX)
		|=> $stable(compare_act)) else $error("active compare changed early");
	freeze_a: assert property (i_nrst && !i_clk_en |=> $stable(count_value) && $stable(compare_output))
		else $error("state moved while frozen");
	pin_mux_a: assert property (i_cfg.action != ACT_NONE |-> o_waveform_pin.out == compare_output)
		else $error("pin not overridden");

endmodule : tpw_timer

// ### core/tpw_pkg.sv
// Package for the 8-bit PWM timer: constants, encodings and carriers.
// Assumes nothing of its surroundings; imported whole by the timer core.
package tpw_pkg;

	// Counter geometry
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

	// Waveform mode selector codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_PHASE = 2'h1;
	localparam logic [1:0] MODE_CTC = 2'h2;
	localparam logic [1:0] MODE_FAST = 2'h3;

	// Output action selector codes
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_NONINV = 2'h2;
	localparam logic [1:0] ACT_INV = 2'h3;

	// Prescaler width and select codes
	localparam int PRE_W = 10;
	localparam logic [2:0] PRE_STOP = 3'h0;
	localparam logic [2:0] PRE_DIV1 = 3'h1;
	localparam logic [2:0] PRE_DIV8 = 3'h2;
	localparam logic [2:0] PRE_DIV32 = 3'h3;
	localparam logic [2:0] PRE_DIV64 = 3'h4;
	localparam logic [2:0] PRE_DIV128 = 3'h5;
	localparam logic [2:0] PRE_DIV256 = 3'h6;

	// Prescaler terminal masks, one per division factor
	localparam logic [PRE_W-1:0] MASK_DIV1 = 10'h000;
	localparam logic [PRE_W-1:0] MASK_DIV8 = 10'h007;
	localparam logic [PRE_W-1:0] MASK_DIV32 = 10'h01f;
	localparam logic [PRE_W-1:0] MASK_DIV64 = 10'h03f;
	localparam logic [PRE_W-1:0] MASK_DIV128 = 10'h07f;
	localparam logic [PRE_W-1:0] MASK_DIV256 = 10'h0ff;
	localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3ff;

	// Configuration carried as one group
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] action;
		logic [2:0] prescale;
		logic async_sel;
	} tpw_cfg_type;

	// Pin drive pair
	typedef struct packed {
		logic out;
		logic oe;
	} tpw_pin_type;

	// Counting direction
	typedef enum {DIR_UP, DIR_DOWN} tpw_dir_type;

endpackage : tpw_pkg

// ### dv/tpw_load.sv
// External load on the waveform pin: measures high time and rising edges.
// Assumes the pin drive pair comes straight from the timer; wire pulled low when undriven.
`timescale 1ns/1ns
module tpw_load
	import tpw_pkg::*;
(
	// Clock and window restart
	input wire logic i_clk_sys,
	input wire logic i_clr,
	// Pin drive pair
	input wire tpw_pin_type i_pin,
	// Measurements
	output logic [15:0] o_high,
	output logic [15:0] o_rises
);
	logic level; // Wire level seen by the load
	logic prev; // Level one cycle ago
	// Pull-down wins when the pin is an input, so a stale level never leaks through
	assign level = i_pin.oe ? i_pin.out : 1'b0;
	// Counts restart on i_clr
	always_ff @(posedge i_clk_sys) begin
		prev <= level;
		if (i_clr) begin
			o_high <= 16'h0000;
			o_rises <= 16'h0000;
		end else begin
			o_high <= o_high + {15'h0000, level};
			o_rises <= o_rises + {15'h0000, level & ~prev};
		end
	end
endmodule : tpw_load

// ### dv/timer8_pwm_waveform_modes_tb_top.sv
// Self-checking bench for the PWM timer: table of waveform cases, then edge cases.
// Assumes tpw_timer and tpw_load; oscillator pin driven only in its own test.
`timescale 1ns/1ns
module timer8_pwm_waveform_modes_tb_top
	import tpw_pkg::*;
	;
	// One waveform case and its expected pin measurements
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] act;
		logic [7:0] cmp;
		logic port;
		logic dir;
		logic [15:0] win;
		logic [15:0] high;
		logic [15:0] rises;
	} tpw_row_type;
	logic i_clk_sys;
	logic i_nrst;
	logic i_clk_en;
	tpw_cfg_type cfg;
	logic wr;
	logic [7:0] wval;
	logic ovf_clr;
	logic m_clr;
	logic port;
	logic dir;
	logic ld_clr;
	logic osc; // Timer oscillator pin level
	logic [7:0] cnt;
	logic [7:0] act_cmp;
	logic cmp_out;
	logic ovf;
	logic mflag;
	tpw_pin_type pin;
	logic [15:0] high;
	logic [15:0] rises;
	logic [7:0] c0;
	int mismatches;
	int compares;
	int cycles;
	tpw_row_type rows [12];
	int n_div [7] = '{1, 8, 32, 64, 128, 256, 1024};
	tpw_timer dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_cfg(cfg),
		.i_compare_wr(wr), .i_compare_value(wval), .i_overflow_clr(ovf_clr), .i_match_clr(m_clr),
		.i_osc_clk(osc), .i_port_out(port), .i_dir_out(dir), .o_count_value(cnt),
		.o_compare_active(act_cmp), .o_compare_output(cmp_out), .o_overflow_flag(ovf),
		.o_match_flag(mflag), .o_waveform_pin(pin));
	tpw_load load_u (.i_clk_sys(i_clk_sys), .i_clr(ld_clr), .i_pin(pin), .o_high(high), .o_rises(rises));
	// 10 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	// Hang guard, sized well above the whole run
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Bounded wait for a count value, sampled mid-cycle
	task automatic wait_cnt(input logic [7:0] v);
		int k;
		k = 0;
		@(negedge i_clk_sys);
		while (cnt !== v && k < 3000) begin
			@(negedge i_clk_sys);
			k++;
		end
		if (k >= 3000) begin
			mismatches++;
			report_and_stop();
		end
	endtask : wait_cnt
	// Mode, action, pin and compare write in one go
	task automatic setup(input tpw_row_type r);
		@(posedge i_clk_sys);
		cfg.mode <= r.mode;
		cfg.action <= r.act;
		wval <= r.cmp;
		wr <= 1'b1;
		port <= r.port;
		dir <= r.dir;
		@(posedge i_clk_sys);
		wr <= 1'b0;
	endtask : setup
	task automatic clr_flags();
		@(posedge i_clk_sys);
		ovf_clr <= 1'b1;
		m_clr <= 1'b1;
		@(posedge i_clk_sys);
		ovf_clr <= 1'b0;
		m_clr <= 1'b0;
	endtask : clr_flags
	initial begin
		i_nrst = 1'b0;
		i_clk_en = 1'b1;
		cfg = '{mode: MODE_FAST, action: ACT_NONINV, prescale: PRE_DIV1, async_sel: 1'b0};
		{wr, wval, ovf_clr, m_clr, port, dir, ld_clr} = 14'h0002;
		osc = 1'b0;
		rows = '{
			'{MODE_FAST, ACT_NONINV, 8'h80, 1'b0, 1'b1, 16'h0200, 16'h0102, 16'h0002},
			'{MODE_FAST, ACT_NONINV, 8'h00, 1'b0, 1'b1, 16'h0200, 16'h0002, 16'h0002},
			'{MODE_FAST, ACT_NONINV, 8'hff, 1'b0, 1'b1, 16'h0200, 16'h0200, 16'h0000},
			'{MODE_FAST, ACT_INV, 8'h80, 1'b0, 1'b1, 16'h0200, 16'h00fe, 16'h0002},
			'{MODE_FAST, ACT_INV, 8'hff, 1'b0, 1'b1, 16'h0200, 16'h0000, 16'h0000},
			'{MODE_FAST, ACT_TOGGLE, 8'h00, 1'b0, 1'b1, 16'h0200, 16'h0100, 16'h0001},
			'{MODE_PHASE, ACT_NONINV, 8'h80, 1'b0, 1'b1, 16'h03fc, 16'h0200, 16'h0002},
			'{MODE_PHASE, ACT_NONINV, 8'h00, 1'b0, 1'b1, 16'h03fc, 16'h0000, 16'h0000},
			'{MODE_PHASE, ACT_NONINV, 8'hff, 1'b0, 1'b1, 16'h03fc, 16'h03fc, 16'h0000},
			'{MODE_PHASE, ACT_INV, 8'h40, 1'b0, 1'b1, 16'h03fc, 16'h02fc, 16'h0002},
			'{MODE_FAST, ACT_NONINV, 8'h80, 1'b1, 1'b0, 16'h0200, 16'h0000, 16'h0000},
			'{MODE_NORMAL, ACT_NONE, 8'h80, 1'b1, 1'b1, 16'h0200, 16'h0200, 16'h0000}};
		repeat (2) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		@(negedge i_clk_sys);
		check({cnt, act_cmp}, 16'h0000);
		// Table: settle 1100 cycles, then measure exactly two periods
		foreach (rows[i]) begin
			setup(rows[i]);
			repeat (1100) @(posedge i_clk_sys);
			ld_clr <= 1'b1;
			@(posedge i_clk_sys);
			ld_clr <= 1'b0;
			repeat (rows[i].win) @(posedge i_clk_sys);
			@(negedge i_clk_sys);
			check(high, rows[i].high);
			check(rises, rows[i].rises);
			$display("test %0d done", i);
		end
		// Buffered compare reaches the comparator only at bottom
		setup('{MODE_FAST, ACT_NONINV, 8'h40, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0});
		repeat (600) @(posedge i_clk_sys);
		wait_cnt(8'h10);
		setup('{MODE_FAST, ACT_NONINV, 8'h90, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0});
		@(negedge i_clk_sys);
		check({8'h00, act_cmp}, 16'h0040);
		wait_cnt(8'h00);
		check({8'h00, act_cmp}, 16'h0090);
		wait_cnt(8'h20);
		clr_flags();
		wait_cnt(8'h90);
		check({14'h0000, ovf, mflag}, 16'h0000);
		@(negedge i_clk_sys);
		check({15'h0000, mflag}, 16'h0001);
		wait_cnt(8'hff);
		check({15'h0000, ovf}, 16'h0001);
		@(negedge i_clk_sys);
		check({8'h00, cnt}, 16'h0000);
		$display("test buffer and flags done");
		// Dual slope turning points
		setup('{MODE_PHASE, ACT_NONINV, 8'h40, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0});
		wait_cnt(8'hff);
		@(negedge i_clk_sys);
		check({8'h00, cnt}, 16'h00fe);
		wait_cnt(8'h10);
		clr_flags();
		wait_cnt(8'h00);
		check({15'h0000, ovf}, 16'h0001);
		@(negedge i_clk_sys);
		check({8'h00, cnt}, 16'h0001);
		$display("test phase turning done");
		// Compare leaving max: output takes the up-match level at max, where the old max compare still matches
		setup('{MODE_PHASE, ACT_NONINV, 8'hff, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0});
		wait_cnt(8'hff);
		setup('{MODE_PHASE, ACT_NONINV, 8'h80, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0});
		wait_cnt(8'hff);
		check({15'h0000, cmp_out}, 16'h0001);
		@(negedge i_clk_sys);
		check({15'h0000, cmp_out}, 16'h0000);
		$display("test leaving max done");
		// Every prescale factor: exactly five ticks per 5*N cycles
		setup('{MODE_FAST, ACT_NONINV, 8'h40, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0});
		for (int i = 0; i < 7; i++) begin
			@(posedge i_clk_sys);
			cfg.prescale <= 3'(i + 1);
			repeat (2 * n_div[i]) @(negedge i_clk_sys);
			c0 = cnt;
			repeat (5 * n_div[i]) @(negedge i_clk_sys);
			check({8'h00, cnt}, {8'h00, c0 + 8'h05});
		end
		$display("test prescale done");
		// Frozen tick leaves the count alone
		@(posedge i_clk_sys);
		cfg.prescale <= PRE_DIV1;
		i_clk_en <= 1'b0;
		@(negedge i_clk_sys);
		c0 = cnt;
		repeat (20) @(negedge i_clk_sys);
		check({8'h00, cnt}, {8'h00, c0});
		@(posedge i_clk_sys);
		i_clk_en <= 1'b1;
		$display("test freeze done");
		// Oscillator pin as tick source: five pin rises give five counts
		@(posedge i_clk_sys);
		cfg.async_sel <= 1'b1;
		@(negedge i_clk_sys);
		c0 = cnt;
		repeat (5) begin
			@(posedge i_clk_sys);
			osc <= 1'b1;
			repeat (3) @(posedge i_clk_sys);
			osc <= 1'b0;
			repeat (3) @(posedge i_clk_sys);
		end
		@(negedge i_clk_sys);
		check({8'h00, cnt}, {8'h00, c0 + 8'h05});
		@(posedge i_clk_sys);
		cfg.async_sel <= 1'b0;
		$display("test oscillator tick done");
		// Second reset in mid-run
		@(posedge i_clk_sys);
		i_nrst <= 1'b0;
		@(posedge i_clk_sys);
		i_nrst <= 1'b1;
		@(negedge i_clk_sys);
		check({cnt, act_cmp}, 16'h0000);
		check({13'h0000, ovf, mflag, cmp_out}, 16'h0000);
		$display("test reset done");
		report_and_stop();
	end
endmodule : timer8_pwm_waveform_modes_tb_top
